//--- bench/lpst_chan_model.sv
// ==========================================
// analog channels behind their comparators
module lpst_chan_model
(
  input wire logic clk,
  input wire logic [47:0] thr,
  input wire logic [47:0] volt,
  output logic [3:0] lvl
);
  timeunit 1ns;
  timeprecision 1ps;
  initial lvl = 4'h0;
  always @(posedge clk)
    for (int i = 0; i < 4; i++)
      lvl[i] <= volt[12*i+:12] > thr[12*i+:12];
endmodule // lpst_chan_model

//--- bench/lpst_chk_assertions.sv
// ==========================================
// port checker
module lpst_chk
(
  input wire logic SYS_CLK,
  input wire logic SRST,
  input wire logic [3:0] ADDR,
  input wire logic [31:0] WDATA,
  input wire logic WR,
  input wire logic [47:0] THRESHOLDS,
  input wire logic TRIG,
  input wire logic ACQ_START,
  input wire logic ARMED
);
  timeunit 1ns;
  timeprecision 1ps;
  logic auto_q;
  logic auto_d;
  // shadow of the auto bit, ports give no other view of the mode
  always_comb
  begin
    auto_d = auto_q;
    if (WR && ADDR == 4'h0)
      auto_d = WDATA[6];
  end
  always_ff @(posedge SYS_CLK)
    auto_q <= SRST ? 1'b0 : auto_d;
  default clocking @(posedge SYS_CLK);
  endclocking
  default disable iff (SRST);
  sequence arm_s;
    WR && ADDR == 4'h0 && WDATA[8] && !ARMED;
  endsequence
  sequence disarm_s;
    WR && ADDR == 4'h0 && !WDATA[8];
  endsequence
  // ==========================================
  // assertions
  AST_TRIG_PULSE: assert property (TRIG |=> !TRIG)
    else $error("trigger pulse too long");
  AST_ACQ_PULSE: assert property (ACQ_START |=> !ACQ_START)
    else $error("acquisition pulse too long");
  AST_TRIG_ARMED: assert property (TRIG |-> $past(ARMED))
    else $error("trigger while not evaluating");
  AST_NORMAL: assert property (ACQ_START && !$past(auto_q) |-> TRIG)
    else $error("acquisition without trigger");
  AST_TRIG_ACQ: assert property (TRIG |-> ACQ_START)
    else $error("trigger without acquisition");
  AST_ARM_HOLD: assert property (arm_s |=> !ARMED [*8] ##[1:40] ARMED)
    else $error("holdoff not kept");
  AST_DISARM: assert property (disarm_s |-> ##[1:3] !ARMED)
    else $error("still evaluating after disarm");
  AST_RESET: assert property (disable iff (1'b0) SRST |=> !TRIG
    && !ACQ_START && !ARMED && THRESHOLDS == {4{12'h800}})
    else $error("outputs not cleared by reset");
endmodule // lpst_chk
bind lpst_top lpst_chk i_chk (.SYS_CLK, .SRST, .ADDR, .WDATA, .WR,
  .THRESHOLDS, .TRIG, .ACQ_START, .ARMED);

//--- bench/tb_top.sv
// ==========================================
// top bench
module tb_top
  import lpst_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic [3:0] addr = 4'h0;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [47:0] volt = {4{12'h400}};
  logic [31:0] rdata;
  logic [3:0] lin;
  logic [47:0] thr;
  logic trig;
  logic acq;
  logic armed;
  int failures = 0;
  int cmp_count = 0;
  int n_trig;
  int n_acq;
  always #25 clk = ~clk;
  lpst_top i_dut (.SYS_CLK(clk), .SRST(srst), .ADDR(addr), .WDATA(wdata),
    .WR(wr), .RD(rd), .RDATA(rdata), .LOGIC_IN(lin), .THRESHOLDS(thr),
    .TRIG(trig), .ACQ_START(acq), .ARMED(armed));
  lpst_chan_model i_chan (.clk(clk), .thr(thr), .volt(volt), .lvl(lin));
  // ==========================================
  // helpers
  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    cmp_count++;
    if (g !== e)
    begin
      failures++;
      $display("FAIL %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic wr_reg(logic [3:0] a, logic [31:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(logic [3:0] a, output logic [31:0] d);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic set_in(logic [3:0] b);
    @(posedge clk);
    for (int i = 0; i < 4; i++)
      volt[12*i+:12] <= b[i] ? 12'hC00 : 12'h400;
  endtask
  task automatic cnt(int n);
    repeat (n)
    begin
      @(posedge clk);
      #1;
      n_trig += (trig === 1'b1);
      n_acq += (acq === 1'b1);
    end
  endtask
  // disarm, settle inputs, arm, let holdoff run out
  task automatic arm(logic [31:0] c, logic [3:0] b);
    wr_reg(LPST_REG_CTRL, 32'h0);
    set_in(b);
    wr_reg(LPST_REG_CTRL, c | 32'h100);
    cnt(40);
    n_trig = 0;
    n_acq = 0;
  endtask
  // ==========================================
  // scenarios
  task automatic t_reset();
    logic [31:0] d;
    rd_reg(LPST_REG_COND, d);
    chk("cond", 32'hFF, d);
    rd_reg(LPST_REG_QTIME, d);
    chk("qtime", 32'h14, d);
    rd_reg(LPST_REG_HOLDOFF, d);
    chk("holdoff", 32'h10, d);
    rd_reg(4'h6, d);
    chk("unmapped", 32'h0, d);
    rd_reg(4'hC, d);
    chk("unmapped hi", 32'h0, d);
    wr_reg(LPST_REG_THR_BASE + 4'h1, 32'hD00);
    set_in(4'hF);
    cnt(6);
    chk("thr2 pin", 32'hD00, thr[23:12]);
    rd_reg(LPST_REG_STATUS, d);
    chk("sync in", 32'hD, d[4:1]);
    wr_reg(LPST_REG_THR_BASE + 4'h1, 32'h800);
  endtask
  task automatic t_pattern();
    logic re;
    logic fe;
    wr_reg(LPST_REG_COND, 32'h09);
    for (int p = 0; p < 2; p++)
      for (int f = 0; f < 4; f++)
      begin
        re = (f == 0 && p == 0) || (f == 1 && p == 1);
        fe = (f == 1 && p == 0) || (f == 0 && p == 1);
        arm({p[0], f[1:0], 1'b0}, 4'h0);
        set_in(4'h1);
        cnt(30);
        chk("rise", re, n_trig);
        set_in(4'h0);
        cnt(30);
        chk("fall", re + fe, n_trig);
      end
  endtask
  task automatic t_state();
    logic [4:0] tc [5] = '{5'h03, 5'h00, 5'h13, 5'h0A, 5'h0F};
    for (int k = 0; k < 5; k++)
    begin
      wr_reg(LPST_REG_COND, {tc[k][4], 7'h01});
      arm({tc[k][3], 6'h0, 1'b1}, {tc[k][2], 2'b0, tc[k][1]});
      set_in({~tc[k][2], 2'b0, tc[k][1]});
      cnt(30);
      chk("state", tc[k][0], n_trig);
    end
  endtask
  task automatic t_qual();
    wr_reg(LPST_REG_COND, 32'h01);
    for (int k = 0; k < 4; k++)
    begin
      arm({k[1] ? 2'h2 : 2'h1, 4'h0}, 4'h0);
      set_in(4'h1);
      cnt(k[0] ^ k[1] ? 40 : 8);
      set_in(4'h0);
      cnt(30);
      chk("qual", !k[0], n_trig);
    end
  endtask
  task automatic t_mode();
    wr_reg(LPST_REG_AUTOTO, 32'd200);
    arm(32'h40, 4'h0);
    cnt(300);
    chk("auto acq", 1, n_acq > 0);
    arm(32'h0, 4'h0);
    cnt(300);
    chk("normal acq", 0, n_acq);
  endtask
  task automatic t_srst();
    logic [31:0] d;
    wr_reg(LPST_REG_THR_BASE, 32'h900);
    arm(32'h0, 4'h0);
    chk("armed on", 1, armed);
    @(posedge clk);
    srst <= 1'b1;
    repeat (2) @(posedge clk);
    srst <= 1'b0;
    #1 chk("armed", 0, armed);
    chk("thr1 pin", 32'h800, thr[11:0]);
    rd_reg(LPST_REG_STATUS, d);
    chk("status", 32'h0, d);
  endtask
  task automatic tally_and_finish();
    $display("compares %0d failures %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial
  begin
    repeat (12) @(posedge clk);
    srst <= 1'b0;
    t_reset();
    t_pattern();
    t_state();
    t_qual();
    t_mode();
    t_srst();
    tally_and_finish();
  end
endmodule // tb_top

//--- hdl/lpst_pkg.sv
package lpst_pkg;
  // ==========================================================
  // register offsets (word index, byte address = 4 * index)
  localparam logic [3:0] LPST_REG_CTRL = 4'h0;
  localparam logic [3:0] LPST_REG_COND = 4'h1;
  localparam logic [3:0] LPST_REG_HOLDOFF = 4'h2;
  localparam logic [3:0] LPST_REG_QTIME = 4'h3;
  localparam logic [3:0] LPST_REG_AUTOTO = 4'h4;
  localparam logic [3:0] LPST_REG_STATUS = 4'h5;
  localparam logic [3:0] LPST_REG_THR_BASE = 4'h8;
  localparam int LPST_ADDR_W = 4;
  localparam int LPST_DATA_W = 32;
  localparam int LPST_THR_W = 12;
  localparam int LPST_CNT_W = 32;
  localparam int LPST_NIN = 4;
  // ==========================================================
  // control fields
  localparam int LPST_CTRL_CLASS = 0;
  localparam int LPST_CTRL_FUNC_LO = 1;
  localparam int LPST_CTRL_FALSE = 3;
  localparam int LPST_CTRL_QUAL_LO = 4;
  localparam int LPST_CTRL_AUTO = 6;
  localparam int LPST_CTRL_EDGE = 7;
  localparam int LPST_CTRL_ARM = 8;
  // ==========================================================
  // reset values
  localparam logic [8:0] LPST_CTRL_RST = 9'h000;
  localparam logic [7:0] LPST_COND_RST = 8'hFF;
  localparam logic [31:0] LPST_HOLDOFF_RST = 32'h00000010;
  localparam logic [31:0] LPST_QTIME_RST = 32'h00000014;
  localparam logic [31:0] LPST_AUTOTO_RST = 32'h000F4240;
  localparam logic [11:0] LPST_THR_RST = 12'h800;
  // ==========================================================
  // encodings
  localparam logic [1:0] LPST_PRE_X = 2'h0;
  localparam logic [1:0] LPST_PRE_H = 2'h1;
  localparam logic [1:0] LPST_PRE_L = 2'h2;
  localparam logic [1:0] LPST_FN_AND = 2'h0;
  localparam logic [1:0] LPST_FN_NAND = 2'h1;
  localparam logic [1:0] LPST_FN_OR = 2'h2;
  localparam logic [1:0] LPST_FN_NOR = 2'h3;
  localparam logic [1:0] LPST_Q_NONE = 2'h0;
  localparam logic [1:0] LPST_Q_LESS = 2'h1;
  localparam logic [1:0] LPST_Q_MORE = 2'h2;
  typedef enum logic [3:0] {
    LPST_S_IDLE = 4'b0001,
    LPST_S_HOLD = 4'b0010,
    LPST_S_EVAL = 4'b0100,
    LPST_S_TIME = 4'b1000
  } lpst_state_t;
endpackage

//--- hdl/lpst_thr_mem.sv
// ==========================================================
// per-channel threshold store, registered read
module lpst_thr_mem
(
  input wire logic clk,
  input wire logic rst,
  input wire logic we,
  input wire logic [1:0] wa,
  input wire logic [lpst_pkg::LPST_THR_W-1:0] wd,
  input wire logic [1:0] ra,
  output logic [lpst_pkg::LPST_THR_W-1:0] rd,
  output logic [lpst_pkg::LPST_NIN*lpst_pkg::LPST_THR_W-1:0] all_thr
);
  import lpst_pkg::*;
  logic [LPST_THR_W-1:0] mem_q [LPST_NIN];
  logic [LPST_THR_W-1:0] mem_d [LPST_NIN];
  logic [LPST_THR_W-1:0] rd_d;

  always_comb
  begin
    for (int i = 0; i < LPST_NIN; i++)
    begin
      mem_d[i] = (we && wa == 2'(i)) ? wd : mem_q[i];
    end
    rd_d = mem_q[ra];
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      for (int i = 0; i < LPST_NIN; i++)
      begin
        mem_q[i] <= LPST_THR_RST;
      end
      rd <= LPST_THR_RST;
    end
    else
    begin
      for (int i = 0; i < LPST_NIN; i++)
      begin
        mem_q[i] <= mem_d[i];
      end
      rd <= rd_d;
    end
  end

  genvar g;
  generate
    for (g = 0; g < LPST_NIN; g++)
    begin : g_flat
      assign all_thr[g*LPST_THR_W +: LPST_THR_W] = mem_q[g];
    end
  endgenerate
endmodule // lpst_thr_mem

//--- hdl/lpst_top.sv
// Behaviour
// R1: two classes, pattern (levels) and state (clock edge), chosen by software.
// R2: pattern uses all four inputs, each high, low or don't care.
// R3: precondition results combine with AND, NAND, OR or NOR.
// R4: polarity chooses firing on function going true or going false.
// R5: pattern class may qualify the true condition by its duration.
// R6: state class uses input 4 as clock, rising or falling edge.
// R7: state class evaluates inputs 1 to 3 only; clock excluded.
// R8: pattern: after holdoff, sample inputs and fire if condition met.
// R9: state: after holdoff wait for edge, sample, fire if condition holds.
// R10: AND all match, NAND one fails, OR any, NOR none match.
// R11: going-false swaps AND with NAND and OR with NOR.
// R12: each input channel has its own threshold setting.
// R13: auto or normal mode and adjustable holdoff gate evaluation.
// R14: less-than fires if true shorter; more-than if true longer.
// R15: auto mode starts acquisition after timeout without a trigger.
// R16: normal mode starts acquisition only on a valid trigger.
// R17: reset clears pending trigger, holdoff, interval; trigger is one pulse.
module lpst_top
(
  input wire logic SYS_CLK,
  input wire logic SRST,
  input wire logic [lpst_pkg::LPST_ADDR_W-1:0] ADDR,
  input wire logic [lpst_pkg::LPST_DATA_W-1:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [lpst_pkg::LPST_DATA_W-1:0] RDATA,
  input wire logic [lpst_pkg::LPST_NIN-1:0] LOGIC_IN,
  output logic [lpst_pkg::LPST_NIN*lpst_pkg::LPST_THR_W-1:0] THRESHOLDS,
  output logic TRIG,
  output logic ACQ_START,
  output logic ARMED
);
  import lpst_pkg::*;

  // ==========================================================
  // input synchronisers
  logic [LPST_NIN-1:0] s1_q, s2_q, s3_q;
  always_ff @(posedge SYS_CLK)
  begin
    if (SRST)
    begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
    end
    else
    begin
      s1_q <= LOGIC_IN;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // ==========================================================
  // registers
  logic [8:0] ctrl_q, ctrl_d;
  logic [7:0] cond_q, cond_d;
  logic [31:0] hold_q, hold_d, qt_q, qt_d, ato_q, ato_d;
  logic [LPST_DATA_W-1:0] rdata_d;
  logic thr_we;
  logic trig_seen_q, trig_seen_d;
  lpst_state_t st_q, st_d;

  // words 12 to 15 fall outside the window and must not alias thresholds
  function automatic logic is_thr(input logic [LPST_ADDR_W-1:0] a);
    is_thr = a[3:2] == LPST_REG_THR_BASE[3:2];
  endfunction

  assign thr_we = WR && is_thr(ADDR);

  // R12 per-channel thresholds
  lpst_thr_mem u_thr (
    .clk(SYS_CLK),
    .rst(SRST),
    .we(thr_we),
    .wa(ADDR[1:0]),
    .wd(WDATA[LPST_THR_W-1:0]),
    .ra(ADDR[1:0]),
    .rd(),
    .all_thr(THRESHOLDS)
  );

  always_comb
  begin
    ctrl_d = ctrl_q;
    cond_d = cond_q;
    hold_d = hold_q;
    qt_d = qt_q;
    ato_d = ato_q;
    if (WR)
    begin
      unique case (ADDR)
        LPST_REG_CTRL: ctrl_d = WDATA[8:0];
        LPST_REG_COND: cond_d = WDATA[7:0];
        LPST_REG_HOLDOFF: hold_d = WDATA;
        LPST_REG_QTIME: qt_d = WDATA;
        LPST_REG_AUTOTO: ato_d = WDATA;
        default: ;
      endcase
    end
    rdata_d = '0;
    if (RD)
    begin
      unique case (ADDR)
        LPST_REG_CTRL: rdata_d = {23'h0, ctrl_q};
        LPST_REG_COND: rdata_d = {24'h0, cond_q};
        LPST_REG_HOLDOFF: rdata_d = hold_q;
        LPST_REG_QTIME: rdata_d = qt_q;
        LPST_REG_AUTOTO: rdata_d = ato_q;
        LPST_REG_STATUS: rdata_d = {26'h0, trig_seen_q, s2_q, ARMED};
        default:
        begin
          // flat copy is used, the memory port answers a cycle too late
          if (is_thr(ADDR))
            rdata_d = {20'h0, THRESHOLDS[ADDR[1:0]*LPST_THR_W +: LPST_THR_W]};
        end
      endcase
    end
  end

  always_ff @(posedge SYS_CLK)
  begin
    if (SRST)
    begin
      ctrl_q <= LPST_CTRL_RST;
      cond_q <= LPST_COND_RST;
      hold_q <= LPST_HOLDOFF_RST;
      qt_q <= LPST_QTIME_RST;
      ato_q <= LPST_AUTOTO_RST;
    end
    else
    begin
      ctrl_q <= ctrl_d;
      cond_q <= cond_d;
      hold_q <= hold_d;
      qt_q <= qt_d;
      ato_q <= ato_d;
    end
  end

  // read data registered straight onto the port, one cycle after RD
  always_ff @(posedge SYS_CLK)
  begin
    if (SRST)
      RDATA <= '0;
    else
      RDATA <= rdata_d;
  end

  // ==========================================================
  // condition evaluation
  logic cls_state, fals, auto_m, edge_fall, arm;
  logic [1:0] fn, qual;
  // R1 class select
  assign cls_state = ctrl_q[LPST_CTRL_CLASS];
  assign fn = ctrl_q[LPST_CTRL_FUNC_LO +: 2];
  assign fals = ctrl_q[LPST_CTRL_FALSE];
  assign qual = ctrl_q[LPST_CTRL_QUAL_LO +: 2];
  assign auto_m = ctrl_q[LPST_CTRL_AUTO];
  assign edge_fall = ctrl_q[LPST_CTRL_EDGE];
  assign arm = ctrl_q[LPST_CTRL_ARM];

  function automatic logic fn_eval(input logic [1:0] f,
                                   input logic [3:0] en,
                                   input logic [3:0] mt);
    logic all_m, any_m;
    all_m = &(mt | ~en);
    any_m = |(mt & en);
    unique case (f)
      LPST_FN_AND: fn_eval = all_m;
      LPST_FN_NAND: fn_eval = !all_m;
      LPST_FN_OR: fn_eval = any_m;
      default: fn_eval = !any_m;
    endcase
  endfunction

  logic [3:0] en, mt;
  logic [1:0] fsel;
  logic cond;
  always_comb
  begin
    for (int i = 0; i < LPST_NIN; i++)
    begin
      // R2 don't care excluded
      en[i] = cond_q[2*i +: 2] != LPST_PRE_X;
      mt[i] = (cond_q[2*i +: 2] == LPST_PRE_H) ? s2_q[i] : !s2_q[i];
    end
    // R7 clock input not evaluated
    if (cls_state)
      en[3] = 1'b0;
    // R4 R11 polarity swaps pairs
    fsel = fals ? {fn[1], !fn[0]} : fn;
    // R3 R10 boolean combine
    cond = fn_eval(fsel, en, mt);
  end

  // R6 clock edge detect on synchronised input 4
  logic clk_edge;
  assign clk_edge = edge_fall ? (s3_q[3] && !s2_q[3])
                              : (!s3_q[3] && s2_q[3]);

  // ==========================================================
  // sequencer
  logic [31:0] hc_q, hc_d, ac_q, ac_d;
  logic trig_d, acq_d, armed_d, prev_q, prev_d;
  always_comb
  begin
    st_d = st_q;
    hc_d = hc_q;
    ac_d = ac_q;
    prev_d = cond;
    trig_d = 1'b0;
    acq_d = 1'b0;
    trig_seen_d = trig_seen_q;
    unique case (st_q)
      LPST_S_IDLE:
      begin
        hc_d = '0;
        ac_d = '0;
        if (arm)
          st_d = LPST_S_HOLD;
      end
      // R13 holdoff gates evaluation
      LPST_S_HOLD:
      begin
        hc_d = hc_q + 32'h1;
        if (hc_q >= hold_q)
        begin
          st_d = LPST_S_EVAL;
          hc_d = '0;
          ac_d = '0;
        end
      end
      LPST_S_EVAL:
      begin
        ac_d = ac_q + 32'h1;
        if (cls_state)
        begin
          // R9 sample on selected edge
          if (clk_edge && cond)
            trig_d = 1'b1;
        end
        // R8 pattern fires on condition
        else if (cond && !prev_q)
        begin
          // R5 optional duration qualification
          if (qual == LPST_Q_NONE)
            trig_d = 1'b1;
          else
          begin
            st_d = LPST_S_TIME;
            hc_d = '0;
          end
        end
        // R15 auto timeout
        if (!trig_d && auto_m && ac_q >= ato_q && st_d == LPST_S_EVAL)
        begin
          acq_d = 1'b1;
          st_d = arm ? LPST_S_HOLD : LPST_S_IDLE;
          hc_d = '0;
        end
      end
      LPST_S_TIME:
      begin
        hc_d = hc_q + 32'h1;
        // R14 less or more than
        if (!cond)
        begin
          trig_d = (qual == LPST_Q_LESS) ? (hc_q < qt_q) : (hc_q > qt_q);
          st_d = trig_d ? LPST_S_TIME : LPST_S_EVAL;
        end
      end
    endcase
    if (trig_d)
    begin
      // R16 acquisition only on trigger in normal mode
      acq_d = 1'b1;
      trig_seen_d = 1'b1;
      st_d = arm ? LPST_S_HOLD : LPST_S_IDLE;
      hc_d = '0;
    end
    if (!arm)
      st_d = LPST_S_IDLE;
    armed_d = st_d == LPST_S_EVAL || st_d == LPST_S_TIME;
  end

  always_ff @(posedge SYS_CLK)
  begin
    // R17 reset clears pending state
    if (SRST)
    begin
      st_q <= LPST_S_IDLE;
      hc_q <= '0;
      ac_q <= '0;
      prev_q <= 1'b1;
      TRIG <= 1'b0;
      ACQ_START <= 1'b0;
      ARMED <= 1'b0;
      trig_seen_q <= 1'b0;
    end
    else
    begin
      st_q <= st_d;
      hc_q <= hc_d;
      ac_q <= ac_d;
      prev_q <= prev_d;
      // R17 single cycle pulse
      TRIG <= trig_d;
      ACQ_START <= acq_d;
      ARMED <= armed_d;
      trig_seen_q <= trig_seen_d;
    end
  end
endmodule // lpst_top
